// [src/acs_adc_sequencer.sv]
`timescale 1ns/1ps
// Overview of operation
// R1 - result upper 8 bits high, low 2 bits top
// R2 - six lowest result bits read zero
// R3 - inputs 0/4 to A, 1/5 B, 2/6 C, 3/7 D
// R4 - results cleared on reset and standby
// R5 - control/status cleared on reset and standby
// R6 - end flag set at single or scan end
// R7 - end flag cleared by read-one then write-zero
// R8 - interrupt request only when enable bit set
// R9 - start stays set, single mode self-clears
// R10 - scan repeats until start bit cleared
// R11 - start set by software or trigger pin
// R12 - bit 4 picks single or scan mode
// R13 - bit 3 picks 266 or 134 states
// R14 - channel field picks input or scan group
// R15 - software stops before changing mode or channels
// R16 - enabled trigger starts on falling edge
// R17 - trigger register low seven bits read one
// R18 - trigger register reset value seven ones
// R19 - high read returns byte, latches low byte
// R20 - software reads high byte before low byte
// R21 - scan starts group first, restarts after stop
// R22 - later scan conversions 256 or 128 states
// R23 - scan end sets flag and restarts group
// R24 - result and end flag update together
module acs_adc_sequencer
   import acs_pkg::*;
(
   input wire logic i_clock,               // system clock, 250 MHz
   input wire logic i_rst,                 // async reset, active high
   input wire logic i_standby,             // standby entry, same clock
   input wire logic [15:0] i_addr,         // internal bus address
   input wire logic i_rd,                  // read strobe, one cycle
   input wire logic i_wr,                  // write strobe, one cycle
   input wire logic [7:0] i_wdata,         // write data
   output logic [7:0] o_rdata,             // read data, next cycle
   input wire logic i_ext_trigger_n,       // external trigger pin
   input wire logic [9:0] i_analog_result, // result from analog core
   output logic [2:0] o_sample_chan,       // analog input in use
   output logic o_conv_busy,               // conversion in progress
   output logic o_conv_end_irq             // conversion-end request
);

   import acs_pkg::*;

   acs_state_t s_reg;
   acs_state_t s_next;

   logic trig_fall;
   logic [3:0] rd_off;
   logic [1:0] bank_rd_sel;
   logic [7:0] bank_high;
   logic [7:0] bank_low;
   logic bank_wr;
   logic [2:0] cur_chan;
   logic [8:0] first_len;
   logic [8:0] next_len;
   logic scan_last;

   // address inside the block's window
   function automatic logic addr_hit(input logic [15:0] addr);
      addr_hit = (addr >= ADDR_RESULT_A_HIGH) && (addr <= ADDR_TRIG_CTRL);
   endfunction : addr_hit

   // offset from the first result register
   function automatic logic [3:0] addr_off(input logic [15:0] addr);
      logic [15:0] diff;
      diff = addr - ADDR_RESULT_A_HIGH;
      addr_off = diff[3:0];
   endfunction : addr_off

   // control/status read view
   function automatic logic [7:0] csr_view(input acs_state_t st);
      logic [7:0] v;
      v = CSR_RESET;
      v[CSR_END_FLAG_BIT] = st.end_flag;
      v[CSR_IRQ_ENABLE_BIT] = st.irq_en;
      v[CSR_START_BIT] = st.start;
      v[CSR_SCAN_BIT] = st.scan;
      v[CSR_TIME_SEL_BIT] = st.time_sel;
      v[CSR_CHAN_MSB:0] = st.chan_field;
      csr_view = v;
   endfunction : csr_view

   // falling-edge detect on the trigger pin
   acs_edge_sync u_trig_sync (
      .i_clock (i_clock),
      .i_rst (i_rst),
      .i_pin (i_ext_trigger_n),
      .o_fall (trig_fall)
   );

   // four result registers
   acs_result_bank u_bank (
      .i_clock (i_clock),
      .i_rst (i_rst),
      .i_clear (i_standby),                 // [R4]
      .i_wr_en (bank_wr),
      .i_wr_sel (cur_chan[1:0]),            // [R3]
      .i_wr_data (i_analog_result),         // [R1]
      .i_rd_sel (bank_rd_sel),
      .o_high_byte (bank_high),
      .o_low_byte (bank_low)                // [R2]
   );

   // read decode
   assign rd_off = addr_off(i_addr);
   assign bank_rd_sel = rd_off[2:1];

   // channel under conversion: fixed input or group base plus step
   always_comb
   begin
      if (s_reg.scan)
         cur_chan = {s_reg.chan_field[2], s_reg.step};   // [R14] [R21]
      else
         cur_chan = s_reg.chan_field;                    // [R14]
   end

   // conversion lengths chosen by the time select bit
   always_comb
   begin
      if (s_reg.time_sel)
      begin
         first_len = CONV_SHORT_FIRST_CYC;               // [R13]
         next_len = CONV_SHORT_NEXT_CYC;                 // [R22]
      end
      else
      begin
         first_len = CONV_LONG_FIRST_CYC;                // [R13]
         next_len = CONV_LONG_NEXT_CYC;                  // [R22]
      end
   end

   // last channel of the scan group reached
   assign scan_last = (s_reg.step == s_reg.chan_field[1:0]);

   // next state: bus, sequencer, trigger, standby
   always_comb
   begin
      s_next = s_reg;
      bank_wr = 1'b0;

      // bus read, data registered for the next cycle
      if (i_rd)
      begin
         s_next.rdata = UNMAPPED_READ;
         if (addr_hit(i_addr))
         begin
            if (rd_off < 4'h8)
            begin
               if (!rd_off[0])
               begin
                  s_next.rdata = bank_high;              // [R19]
                  s_next.hold = bank_low;                // [R19]
               end
               else
               begin
                  s_next.rdata = s_reg.hold;             // [R19]
               end
            end
            else if (i_addr == ADDR_CONV_CTRL_STATUS)
            begin
               s_next.rdata = csr_view(s_reg);
               if (s_reg.end_flag)
                  s_next.clear_armed = 1'b1;             // [R7]
            end
            else
            begin
               s_next.rdata = {s_reg.trig_en, TRIG_RESERVED_ONES}; // [R17]
            end
         end
      end

      // bus write
      if (i_wr && (i_addr == ADDR_CONV_CTRL_STATUS))
      begin
         s_next.irq_en = i_wdata[CSR_IRQ_ENABLE_BIT];
         s_next.start = i_wdata[CSR_START_BIT];          // [R11]
         s_next.scan = i_wdata[CSR_SCAN_BIT];            // [R12]
         s_next.time_sel = i_wdata[CSR_TIME_SEL_BIT];    // [R13]
         s_next.chan_field = i_wdata[CSR_CHAN_MSB:0];
         // writing one leaves the flag alone
         if (s_reg.clear_armed && !i_wdata[CSR_END_FLAG_BIT])
            s_next.end_flag = 1'b0;                      // [R7]
         s_next.clear_armed = 1'b0;
      end
      else if (i_wr && (i_addr == ADDR_TRIG_CTRL))
      begin
         s_next.trig_en = i_wdata[TRIG_ENABLE_BIT];      // [R16]
      end

      // sequencer: stop, launch, count down, finish
      if (s_reg.busy && !s_reg.start)
      begin
         s_next.busy = 1'b0;                             // [R10]
         s_next.step = 2'b00;                            // [R21]
      end
      else if (!s_reg.busy && s_reg.start)
      begin
         s_next.busy = 1'b1;                             // [R9]
         s_next.step = 2'b00;                            // [R21]
         s_next.cnt = first_len - 9'h001;                // [R13]
      end
      else if (s_reg.busy)
      begin
         if (s_reg.cnt != 9'h000)
         begin
            s_next.cnt = s_reg.cnt - 9'h001;
         end
         else
         begin
            // result and flag written at the same edge
            bank_wr = 1'b1;                              // [R24]
            if (!s_reg.scan)
            begin
               s_next.end_flag = 1'b1;                   // [R6] [R24]
               s_next.start = 1'b0;                      // [R9]
               s_next.busy = 1'b0;
            end
            else
            begin
               s_next.cnt = next_len - 9'h001;           // [R22]
               if (scan_last)
               begin
                  s_next.end_flag = 1'b1;                // [R6] [R23]
                  s_next.step = 2'b00;                   // [R23]
               end
               else
               begin
                  s_next.step = s_reg.step + 2'b01;      // [R21]
               end
            end
         end
      end

      // enabled trigger sets start, winning over any clear except standby
      if (trig_fall && s_reg.trig_en)
         s_next.start = 1'b1;                            // [R11] [R16]

      // standby returns every register to its reset value
      if (i_standby)
      begin
         s_next = ACS_STATE_RESET;                       // [R5] [R18]
      end
   end

   // single state register
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         s_reg <= ACS_STATE_RESET;                       // [R5] [R18]
      else
         s_reg <= s_next;
   end

   // outputs
   assign o_rdata = s_reg.rdata;
   assign o_sample_chan = cur_chan;
   assign o_conv_busy = s_reg.busy;
   assign o_conv_end_irq = s_reg.end_flag & s_reg.irq_en; // [R8]

endmodule : acs_adc_sequencer

// [src/acs_pkg.sv]
package acs_pkg;

   // register byte addresses on the internal bus
   localparam logic [15:0] ADDR_RESULT_A_HIGH = 16'hffe0;
   localparam logic [15:0] ADDR_RESULT_A_LOW = 16'hffe1;
   localparam logic [15:0] ADDR_RESULT_B_HIGH = 16'hffe2;
   localparam logic [15:0] ADDR_RESULT_B_LOW = 16'hffe3;
   localparam logic [15:0] ADDR_RESULT_C_HIGH = 16'hffe4;
   localparam logic [15:0] ADDR_RESULT_C_LOW = 16'hffe5;
   localparam logic [15:0] ADDR_RESULT_D_HIGH = 16'hffe6;
   localparam logic [15:0] ADDR_RESULT_D_LOW = 16'hffe7;
   localparam logic [15:0] ADDR_CONV_CTRL_STATUS = 16'hffe8;
   localparam logic [15:0] ADDR_TRIG_CTRL = 16'hffe9;

   // conversion control/status field positions
   localparam int CSR_END_FLAG_BIT = 7;
   localparam int CSR_IRQ_ENABLE_BIT = 6;
   localparam int CSR_START_BIT = 5;
   localparam int CSR_SCAN_BIT = 4;
   localparam int CSR_TIME_SEL_BIT = 3;
   localparam int CSR_CHAN_MSB = 2;
   localparam int TRIG_ENABLE_BIT = 7;

   // reset and fixed values
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] TRIG_CTRL_RESET = 8'h7f;
   localparam logic [6:0] TRIG_RESERVED_ONES = 7'h7f;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // conversion lengths in system clock states
   localparam logic [8:0] CONV_LONG_FIRST_CYC = 9'h10a;  // 266 states
   localparam logic [8:0] CONV_SHORT_FIRST_CYC = 9'h086; // 134 states
   localparam logic [8:0] CONV_LONG_NEXT_CYC = 9'h100;   // 256 states
   localparam logic [8:0] CONV_SHORT_NEXT_CYC = 9'h080;  // 128 states

   // whole state of the control block
   typedef struct packed {
      logic end_flag;
      logic irq_en;
      logic start;
      logic scan;
      logic time_sel;
      logic [2:0] chan_field;
      logic trig_en;
      logic clear_armed;
      logic busy;
      logic [8:0] cnt;
      logic [1:0] step;
      logic [7:0] rdata;
      logic [7:0] hold;
   } acs_state_t;

   localparam acs_state_t ACS_STATE_RESET = '0;

endpackage : acs_pkg

// [src/acs_edge_sync.sv]
`timescale 1ns/1ps
module acs_edge_sync (
   input wire logic i_clock, // system clock
   input wire logic i_rst,   // async reset, active high
   input wire logic i_pin,   // asynchronous pin level
   output logic o_fall       // one-cycle pulse on high-to-low
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } acs_sync_t;

   acs_sync_t s_reg;
   acs_sync_t s_next;

   // two-stage synchroniser plus one history stage
   always_comb
   begin
      s_next = s_reg;
      s_next.s1 = i_pin;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
   end

   // idle level of the pin is high
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         s_reg <= '1;
      else
         s_reg <= s_next;
   end

   // edge seen only behind the second stage
   assign o_fall = s_reg.s3 & ~s_reg.s2;

endmodule : acs_edge_sync

// [src/acs_result_bank.sv]
`timescale 1ns/1ps
module acs_result_bank
   import acs_pkg::*;
(
   input wire logic i_clock,            // system clock
   input wire logic i_rst,              // async reset, active high
   input wire logic i_clear,            // synchronous clear (standby)
   input wire logic i_wr_en,            // store a result this cycle
   input wire logic [1:0] i_wr_sel,     // result register to store into
   input wire logic [9:0] i_wr_data,    // 10-bit conversion result
   input wire logic [1:0] i_rd_sel,     // result register to read
   output logic [7:0] o_high_byte,      // upper 8 bits of result
   output logic [7:0] o_low_byte        // lowest 2 bits, left aligned
);

   typedef struct packed {
      logic [3:0][9:0] res;
   } acs_bank_t;

   acs_bank_t s_reg;
   acs_bank_t s_next;

   // store or clear the four results
   always_comb
   begin
      s_next = s_reg;
      for (int i = 0; i < 4; i++)
      begin
         if (i_clear)
            s_next.res[i] = RESULT_RESET;
         else if (i_wr_en && (i_wr_sel == i[1:0]))
            s_next.res[i] = i_wr_data;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   // byte views, reserved low six bits read zero
   assign o_high_byte = s_reg.res[i_rd_sel][9:2];
   assign o_low_byte = {s_reg.res[i_rd_sel][1:0], 6'h00};

endmodule : acs_result_bank

// [testbench/acs_adc_sequencer_sva.sv]
`timescale 1ns/1ps
module acs_adc_sequencer_sva
   import acs_pkg::*;
(
   input wire logic i_clock,        // system clock
   input wire logic i_rst,          // async reset
   input wire logic i_standby,      // standby entry
   input wire logic [15:0] i_addr,  // bus address
   input wire logic i_rd,           // read strobe
   input wire logic i_wr,           // write strobe
   input wire logic [7:0] o_rdata,  // read data
   input wire logic o_conv_busy,    // conversion running
   input wire logic o_conv_end_irq  // end request
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // start bit as seen in a status read
   wire logic held_start = o_rdata[5];
   // port relations
   a_standby_idle: assert property (i_standby |=> !o_conv_busy && !o_conv_end_irq)
      else $error("busy or irq after standby");
   a_trig_ones: assert property (i_rd && i_addr == ADDR_TRIG_CTRL |=> o_rdata[6:0] == 7'h7f)
      else $error("trigger reg low bits not ones");
   a_low_zero: assert property (i_rd && i_addr[15:3] == 13'h1ffc && i_addr[0]
      |=> o_rdata[5:0] == 6'h00) else $error("low byte reserved bits set");
   a_unmapped_zero: assert property (i_rd && i_addr > ADDR_TRIG_CTRL |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_stands: assert property (!i_rd && !i_standby |=> $stable(o_rdata))
      else $error("read data moved without read");
   a_irq_rise: assert property ($rose(o_conv_end_irq) |-> $past(o_conv_busy) || $past(i_wr))
      else $error("irq rose without cause");
   a_irq_fall: assert property ($fell(o_conv_end_irq) |-> $past(i_wr) || $past(i_standby))
      else $error("irq fell without write");
   a_start_held: assert property (i_rd && i_addr == ADDR_CONV_CTRL_STATUS && o_conv_busy
      ##1 o_conv_busy ##1 o_conv_busy |-> $past(held_start)) else $error("start low in conversion");
   // main scenarios
   c_end: cover property ($rose(o_conv_end_irq));
   c_trig: cover property (i_rd && i_addr == ADDR_TRIG_CTRL);
   c_long: cover property (o_conv_busy [*8]);
endmodule : acs_adc_sequencer_sva
bind acs_adc_sequencer acs_adc_sequencer_sva u_sva (.i_clock(i_clock), .i_rst(i_rst),
   .i_standby(i_standby), .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .o_rdata(o_rdata),
   .o_conv_busy(o_conv_busy), .o_conv_end_irq(o_conv_end_irq));

// [testbench/acs_analog_model.sv]
`timescale 1ns/1ps
module acs_analog_model (
   input wire logic [9:0] i_base, // level set by bench
   input wire logic [2:0] i_chan, // input being sampled
   output logic [9:0] o_result    // digitised value
);
   // each input gives its own distinct value
   assign o_result = i_base ^ {1'b0, i_chan, 3'h0, i_chan};
endmodule : acs_analog_model

// [testbench/acs_adc_sequencer_bench.sv]
`timescale 1ns/1ps
module acs_adc_sequencer_bench;
   import acs_pkg::*;
   logic i_clock = 0, i_rst = 1, i_standby = 0, i_rd = 0, i_wr = 0, trig_n = 1;
   logic [15:0] i_addr = 16'h0000;
   logic [7:0] i_wdata = 8'h00, o_rdata, d, v;
   logic [9:0] base = 10'h000, ana;
   logic [2:0] chan;
   logic busy, irq;
   int errors = 0, checked = 0, seed = 27171, n, bc;
   logic [9:0] exp_res [4] = '{default: 10'h000};
   // clock
   always #2 i_clock = ~i_clock;
   acs_analog_model u_acs_analog_model (.i_base(base), .i_chan(chan), .o_result(ana));
   acs_adc_sequencer u_acs_adc_sequencer (.i_clock(i_clock), .i_rst(i_rst),
      .i_standby(i_standby), .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
      .o_rdata(o_rdata), .i_ext_trigger_n(trig_n), .i_analog_result(ana),
      .o_sample_chan(chan), .o_conv_busy(busy), .o_conv_end_irq(irq));
   task automatic give_verdict;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, o_rdata});
   endtask : rdc
   task automatic wr(input logic [15:0] a, input logic [7:0] x);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= x;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask : wr
   // high byte first, then low byte through the latch
   task automatic chkres(input int i);
      rdc(16'hffe0 + 16'(2 * i), exp_res[i][9:2]);
      rdc(16'hffe1 + 16'(2 * i), {exp_res[i][1:0], 6'h00});
   endtask : chkres
   task automatic wirq(input int lim);
      for (n = 0; n < lim && irq !== 1'b1; n++)
         @(posedge i_clock);
      #1 chk("irq", 16'h1, {15'h0, irq});
   endtask : wirq
   function automatic logic [9:0] ares(input logic [2:0] c);
      return base ^ {1'b0, c, 3'h0, c};
   endfunction : ares
   // main sequence
   initial
   begin
      repeat (4) @(posedge i_clock);
      i_rst <= 1'b0;
      for (int a = 0; a < 11; a++)
         rdc(16'hffe0 + 16'(a), a == 9 ? 8'h7f : 8'h00);
      wr(ADDR_TRIG_CTRL, 8'h80);
      rdc(ADDR_TRIG_CTRL, 8'hff);
      wr(ADDR_TRIG_CTRL, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         base = 10'($random(seed));
         v = {1'b0, c[0], 2'b10, c[1], c[2:0]};
         wr(ADDR_CONV_CTRL_STATUS, v);
         bc = 0;
         for (n = 0; n < 600 && !(bc > 0 && busy !== 1'b1); n++)
         begin
            @(posedge i_clock);
            #1 bc += int'(busy === 1'b1);
         end
         chk("cycles", c[1] ? 16'd134 : 16'd266, 16'(bc));
         chk("irq", {15'h0, c[0]}, {15'h0, irq});
         exp_res[c % 4] = ares(c[2:0]);
         wr(ADDR_CONV_CTRL_STATUS, v & 8'hdf);
         rdc(ADDR_CONV_CTRL_STATUS, v ^ 8'ha0);
         wr(ADDR_CONV_CTRL_STATUS, 8'h00);
         rdc(ADDR_CONV_CTRL_STATUS, 8'h00);
         chkres(c % 4);
      end
      // scan of group 1, three channels, short time
      base = 10'($random(seed));
      wr(ADDR_CONV_CTRL_STATUS, 8'h7e);
      wirq(1000);
      rdc(ADDR_CONV_CTRL_STATUS, 8'hfe);
      for (int i = 0; i < 3; i++)
         exp_res[i] = ares(3'(i + 4));
      for (int i = 0; i < 4; i++)
         chkres(i);
      wr(ADDR_CONV_CTRL_STATUS, 8'h00);
      repeat (2) @(posedge i_clock);
      #1 chk("busy", 16'h0, {15'h0, busy});
      rdc(ADDR_CONV_CTRL_STATUS, 8'h00);
      // standby clears control/status and result register A
      @(posedge i_clock);
      i_standby <= 1'b1;
      @(posedge i_clock);
      i_standby <= 1'b0;
      exp_res = '{default: 10'h000};
      rdc(ADDR_CONV_CTRL_STATUS, 8'h00);
      chkres(0);
      // pin start with trigger enabled, then ignored when disabled
      base = 10'($random(seed));
      wr(ADDR_TRIG_CTRL, 8'h80);
      wr(ADDR_CONV_CTRL_STATUS, 8'h4a);
      @(posedge i_clock);
      trig_n <= 1'b0;
      wirq(400);
      exp_res[2] = ares(3'h2);
      chkres(2);
      trig_n <= 1'b1;
      wr(ADDR_TRIG_CTRL, 8'h00);
      @(posedge i_clock);
      trig_n <= 1'b0;
      repeat (20) @(posedge i_clock);
      #1 chk("busy", 16'h0, {15'h0, busy});
      give_verdict();
   end
   // hang guard
   initial
   begin
      #100000;
      errors++;
      give_verdict();
   end
endmodule : acs_adc_sequencer_bench
